// File: hw/adc_control_and_result_regs.sv
// converter control, prescaler, sequencing and result registers
`timescale 1ns/10ps
`default_nettype none
`include "adc_ctrl_defs.svh"

module adc_control_and_result_regs (
    input  wire logic                       clk,
    input  wire logic                       rst_n,
    input  wire logic                       clk_en,
    input  wire logic [3:0]                 avs_address,
    input  wire logic                       avs_read,
    input  wire logic                       avs_write,
    input  wire logic [31:0]                avs_writedata,
    output logic      [31:0]                avs_readdata,
    output logic                            avs_waitrequest,
    input  wire logic                       global_irq_enable,
    input  wire logic                       irq_vector_ack,
    input  wire logic [9:0]                 core_sample,
    output logic                            done_irq,
    output logic                            core_power_on,
    output logic                            core_sample_strobe,
    output adc_ctrl_pkg::analog_path_s      core_path
);
    import adc_ctrl_pkg::*;

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic [7:0]  input_select_r;
    logic        power_on_r;
    logic        free_run_r;
    logic        done_flag_r;
    logic        done_ie_r;
    logic [2:0]  clk_div_r;
    logic [9:0]  result_r;
    logic        result_lock_r;
    logic        first_pending_r;
    conv_state_e state_r;
    logic [6:0]  presc_r;
    logic [4:0]  cycle_r;
    logic [4:0]  conv_len_r;
    logic [4:0]  active_chan_r;
    logic        bus_ack_r;

    wire wr_sel = avs_write && !bus_ack_r && clk_en;
    wire rd_sel = avs_read && !bus_ack_r && clk_en;
    wire wr_ctl = wr_sel && avs_address == `OFS_CONTROL_STATUS;
    wire wr_mux = wr_sel && avs_address == `OFS_INPUT_SELECT;
    wire start_wr = wr_ctl && avs_writedata[`BIT_START];
    wire power_nxt = wr_ctl ? avs_writedata[`BIT_POWER_ON] : power_on_r;

    // ------------------------------------------------------------
    // prescaler tick
    // ------------------------------------------------------------
    // codes 000 and 001 both divide by two
    logic [6:0] div_mask;
    always_comb begin
        case (clk_div_r)
            3'h0, 3'h1: div_mask = 7'h01;
            3'h2:       div_mask = 7'h03;
            3'h3:       div_mask = 7'h07;
            3'h4:       div_mask = 7'h0F;
            3'h5:       div_mask = 7'h1F;
            3'h6:       div_mask = 7'h3F;
            default:    div_mask = 7'h7F;
        endcase
    end
    wire adc_tick = power_on_r && ((presc_r & div_mask) == div_mask);

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            presc_r <= 7'h00;
        end else if (clk_en) begin
            if (!power_on_r) begin
                presc_r <= 7'h00;
            end else begin
                presc_r <= presc_r + 7'h01;
            end
        end
    end

    // ------------------------------------------------------------
    // conversion sequencer
    // ------------------------------------------------------------
    wire conv_end = state_r == ST_CONV && adc_tick &&
                    cycle_r == conv_len_r - 5'h01;
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_r         <= ST_IDLE;
            cycle_r         <= 5'h00;
            conv_len_r      <= `FIRST_CONV_CYCLES;
            first_pending_r <= 1'b1;
            active_chan_r   <= 5'h00;
        end else if (clk_en) begin
            // power drop aborts; the next start is a long one again
            if (!power_nxt) begin
                state_r         <= ST_IDLE;
                first_pending_r <= 1'b1;
            end else begin
                case (state_r)
                    ST_IDLE: begin
                        if (start_wr) begin
                            state_r         <= ST_CONV;
                            cycle_r         <= 5'h00;
                            active_chan_r   <= input_select_r[4:0];
                            first_pending_r <= 1'b0;
                            conv_len_r      <= first_pending_r ?
                                `FIRST_CONV_CYCLES : `NORMAL_CONV_CYCLES;
                        end
                    end
                    ST_CONV: begin
                        if (adc_tick) begin
                            cycle_r <= cycle_r + 5'h01;
                        end
                        if (conv_end) begin
                            state_r <= ST_DONE;
                        end
                    end
                    ST_DONE: begin
                        if (free_run_r) begin
                            state_r       <= ST_CONV;
                            cycle_r       <= 5'h00;
                            conv_len_r    <= `NORMAL_CONV_CYCLES;
                            active_chan_r <= input_select_r[4:0];
                        end else begin
                            state_r <= ST_IDLE;
                        end
                    end
                    default: state_r <= ST_IDLE;
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // result capture and read lock
    // ------------------------------------------------------------
    wire is_diff = active_chan_r > `CODE_SINGLE_LAST &&
                   active_chan_r <= `CODE_DIFF_LAST;
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            result_r      <= 10'h000;
            result_lock_r <= 1'b0;
        end else if (clk_en) begin
            if (conv_end && power_nxt && !result_lock_r) begin
                // core delivers offset binary; flip msb for signed
                result_r <= is_diff ? {~core_sample[9], core_sample[8:0]}
                                    : core_sample;
            end
            if (rd_sel && avs_address == `OFS_RESULT_LOW) begin
                result_lock_r <= 1'b1;
            end else if (rd_sel && avs_address == `OFS_RESULT_HIGH) begin
                result_lock_r <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // software registers
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            input_select_r <= 8'h00;
            power_on_r     <= 1'b0;
            free_run_r     <= 1'b0;
            done_ie_r      <= 1'b0;
            clk_div_r      <= 3'h0;
        end else if (wr_mux) begin
            input_select_r <= avs_writedata[7:0];
        end else if (wr_ctl) begin
            power_on_r <= avs_writedata[`BIT_POWER_ON];
            free_run_r <= avs_writedata[`BIT_FREE_RUN];
            done_ie_r  <= avs_writedata[`BIT_DONE_IE];
            clk_div_r  <= avs_writedata[2:0];
        end
    end

    // set wins over a clear in the same cycle
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            done_flag_r <= 1'b0;
        end else if (clk_en) begin
            if (conv_end && power_nxt && !result_lock_r) begin
                done_flag_r <= 1'b1;
            end else if ((wr_ctl && avs_writedata[`BIT_DONE_FLAG]) ||
                         irq_vector_ack) begin
                done_flag_r <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // bus answer: one wait state, then data
    // ------------------------------------------------------------
    // start bit falls with the flag unless free run carries on
    wire conv_busy = state_r == ST_CONV ||
                     (state_r == ST_DONE && free_run_r);
    logic [7:0] rd_byte;
    always_comb begin
        rd_byte = 8'h00;
        case (avs_address)
            `OFS_INPUT_SELECT: rd_byte = input_select_r;
            `OFS_CONTROL_STATUS: rd_byte = {power_on_r,
                conv_busy, free_run_r, done_flag_r,
                done_ie_r, clk_div_r};
            // alignment read live, so a change shows at once
            `OFS_RESULT_LOW: rd_byte = input_select_r[`BIT_LEFT_ALIGN] ?
                {result_r[1:0], 6'h00} : result_r[7:0];
            `OFS_RESULT_HIGH: rd_byte = input_select_r[`BIT_LEFT_ALIGN] ?
                result_r[9:2] : {6'h00, result_r[9:8]};
            default: rd_byte = 8'h00;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            bus_ack_r    <= 1'b0;
            avs_readdata <= 32'h0000_0000;
        end else if (clk_en) begin
            bus_ack_r <= (avs_read || avs_write) && !bus_ack_r;
            if (rd_sel) begin
                avs_readdata <= {24'h00_0000, rd_byte};
            end
        end
    end

    // registered, so the answer never glitches off the request pins
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            avs_waitrequest <= 1'b1;
        end else if (clk_en) begin
            avs_waitrequest <= !((avs_read || avs_write) && !bus_ack_r);
        end
    end

    // ------------------------------------------------------------
    // interrupt request and outputs toward the analog side
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            done_irq           <= 1'b0;
            core_power_on      <= 1'b0;
            core_sample_strobe <= 1'b0;
        end else if (clk_en) begin
            done_irq <= done_flag_r && done_ie_r && global_irq_enable;
            core_power_on      <= power_on_r;
            core_sample_strobe <= conv_end;
        end
    end

    // ------------------------------------------------------------
    // analog path decode
    // ------------------------------------------------------------
    // channel comes from the latched code, so a write during a
    // conversion cannot disturb the inputs until it completes; reference follows the register at once
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            core_path <= '0;
        end else if (clk_en) begin
            core_path.reference <= input_select_r[7:6];
            core_path.single_ended <= active_chan_r <= `CODE_SINGLE_LAST ||
                                      active_chan_r >= `CODE_BANDGAP;
            core_path.bandgap  <= active_chan_r == `CODE_BANDGAP;
            core_path.ground   <= active_chan_r == `CODE_GROUND;
            core_path.pos_input <= active_chan_r[2:0];
            core_path.neg_input <= 3'h0;
            core_path.gain_sel  <= 2'h0;
            if (is_diff) begin
                // codes 01xxx: inputs 0/1 over 0, 2/3 over 2
                if (active_chan_r[4] == 1'b0) begin
                    core_path.pos_input <= {1'b0, active_chan_r[2],
                                            active_chan_r[0]};
                    core_path.neg_input <= {1'b0, active_chan_r[2], 1'b0};
                    core_path.gain_sel  <= active_chan_r[1] ? 2'h2 : 2'h1;
                end else begin
                    core_path.pos_input <= active_chan_r[2:0];
                    core_path.neg_input <= active_chan_r[3] ? 3'h2 : 3'h1;
                end
            end
        end
    end
endmodule // adc_control_and_result_regs
`default_nettype wire

// File: hw/adc_ctrl_defs.svh
// register offsets, field positions and timing counts for the converter control
`ifndef ADC_CTRL_DEFS_SVH
`define ADC_CTRL_DEFS_SVH
`define OFS_INPUT_SELECT   4'h0
`define OFS_CONTROL_STATUS 4'h4
`define OFS_RESULT_LOW     4'h8
`define OFS_RESULT_HIGH    4'hC
`define BIT_POWER_ON       7
`define BIT_START          6
`define BIT_FREE_RUN       5
`define BIT_DONE_FLAG      4
`define BIT_DONE_IE        3
`define BIT_LEFT_ALIGN     5
`define FIRST_CONV_CYCLES  5'h19
`define NORMAL_CONV_CYCLES 5'h0D
`define CODE_SINGLE_LAST   5'h07
`define CODE_DIFF_LAST     5'h1D
`define CODE_BANDGAP       5'h1E
`define CODE_GROUND        5'h1F
`endif

// File: hw/adc_ctrl_pkg.sv
// types shared by the converter control block
package adc_ctrl_pkg;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_CONV = 3'b010,
        ST_DONE = 3'b100
    } conv_state_e;
    // analog path steering handed to the converter core
    typedef struct packed {
        logic       single_ended;
        logic [2:0] pos_input;
        logic [2:0] neg_input;
        logic [1:0] gain_sel;   // 0:1x 1:10x 2:200x
        logic       bandgap;
        logic       ground;
        logic [1:0] reference;
    } analog_path_s;
endpackage

// File: test/adc_core_model.sv
// behavioural converter core answering the sample input
`timescale 1ns/10ps
`default_nettype none
module adc_core_model (
    input  wire logic                       core_power_on,
    input  wire adc_ctrl_pkg::analog_path_s core_path,
    output logic [9:0]                      core_sample
);
    import adc_ctrl_pkg::*;
    // ----------
    // sample source
    // ----------
    // unpowered core shows a pattern, never a stale code
    assign core_sample = !core_power_on ? 10'h155
        : core_path.ground ? 10'h000
        : core_path.bandgap ? 10'h3C3
        : core_path.single_ended ? {core_path.pos_input, 7'h35}
        : {core_path.pos_input, core_path.neg_input,
           core_path.gain_sel, 2'h1};
endmodule // adc_core_model
`default_nettype wire

// File: test/adc_control_and_result_regs_checker.sv
// port assertions for the converter control block
`timescale 1ns/10ps
`default_nettype none
module adc_control_and_result_regs_checker (
    input wire logic                       clk,
    input wire logic                       rst_n,
    input wire logic                       avs_read,
    input wire logic                       avs_write,
    input wire logic [31:0]                avs_readdata,
    input wire logic                       avs_waitrequest,
    input wire logic                       global_irq_enable,
    input wire logic                       irq_vector_ack,
    input wire logic                       done_irq,
    input wire logic                       core_power_on,
    input wire logic                       core_sample_strobe,
    input wire adc_ctrl_pkg::analog_path_s core_path
);
    import adc_ctrl_pkg::*;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    // ----------
    // properties
    // ----------
    sequence s_take; (avs_read || avs_write) && avs_waitrequest; endsequence
    sequence s_ack; !avs_waitrequest ##1 avs_waitrequest; endsequence
    // 13 ticks at divide by 2 leave far more than 8 quiet cycles
    sequence s_quiet; !core_sample_strobe [*8]; endsequence
    property p_ack; s_take |=> s_ack; endproperty
    a_ack: assert property (p_ack) else $error("bus answer late");
    property p_upper; !avs_waitrequest |-> avs_readdata[31:8] == 24'h0;
    endproperty
    a_upper: assert property (p_upper) else $error("upper bits set");
    property p_gate; done_irq |-> $past(global_irq_enable); endproperty
    a_gate: assert property (p_gate) else $error("irq not gated");
    // a completion right at the ack edge wins over the clear
    property p_vack; irq_vector_ack ##1 !core_sample_strobe |=> !done_irq;
    endproperty
    a_vack: assert property (p_vack) else $error("irq not cleared");
    property p_gap; core_sample_strobe |=> s_quiet; endproperty
    a_gap: assert property (p_gap) else $error("results too close");
    property p_first; $rose(core_power_on) |-> s_quiet; endproperty
    a_first: assert property (p_first) else $error("early result");
    property p_abort; !core_power_on && !$past(core_power_on)
        |-> !core_sample_strobe; endproperty
    a_abort: assert property (p_abort) else $error("result when off");
    property p_gain; core_path.gain_sel != 2'h3; endproperty
    a_gain: assert property (p_gain) else $error("bad gain code");
endmodule // adc_control_and_result_regs_checker
bind adc_control_and_result_regs adc_control_and_result_regs_checker i_chk (
    .clk, .rst_n, .avs_read, .avs_write, .avs_readdata, .avs_waitrequest,
    .global_irq_enable, .irq_vector_ack, .done_irq, .core_power_on,
    .core_sample_strobe, .core_path);
`default_nettype wire

// File: test/adc_control_and_result_regs_tb.sv
// self-checking bench for the converter control and result registers
`timescale 1ns/10ps
`default_nettype none
module adc_control_and_result_regs_tb;
    import adc_ctrl_pkg::*;
    // ----------
    // signals and instances
    // ----------
    logic         clk, rst_n, avs_read, avs_write, avs_waitrequest;
    logic         global_irq_enable, irq_vector_ack, done_irq;
    logic         core_power_on, core_sample_strobe;
    logic [3:0]   avs_address;
    logic [31:0]  avs_writedata, avs_readdata, q;
    logic [9:0]   core_sample, s;
    analog_path_s core_path;
    int           n_fail, cmp_count, t, cyc, c0, d;
    // select code, positive input, negative input, gain code
    localparam logic [12:0] DT [4] = '{13'h0921, 13'h0B22, 13'h0E4A,
                                       13'h1DA8};
    adc_control_and_result_regs i_dut (.clk, .rst_n, .clk_en(1'b1),
        .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_readdata,
        .avs_waitrequest, .global_irq_enable, .irq_vector_ack, .core_sample,
        .done_irq, .core_power_on, .core_sample_strobe, .core_path);
    adc_core_model i_core (.core_power_on, .core_path, .core_sample);
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    always @(posedge clk) cyc <= cyc + 1;
    // ----------
    // helpers
    // ----------
    task automatic chk(input logic [31:0] sv, ev);
        cmp_count++;
        if (sv !== ev) begin
            n_fail++;
            $display("BAD t=%0t seen=%h exp=%h", $time, sv, ev);
        end
    endtask
    task automatic end_of_test;
        $display("compares=%0d mismatches=%0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic bus(input logic w, input logic [3:0] a,
                       input logic [7:0] dv);
        int n;
        n = 0;
        @(posedge clk);
        avs_address <= a;
        avs_write <= w;
        avs_read <= !w;
        avs_writedata <= {24'h0, dv};
        do begin
            @(posedge clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        q = avs_readdata;
        if (avs_waitrequest !== 1'b0) begin
            n_fail++;
            end_of_test;
        end
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask
    task automatic rdc(input logic [3:0] a, input logic [7:0] e);
        bus(1'b0, a, 8'h00);
        chk(q, {24'h0, e});
    endtask
    // counts cycles to the next result strobe; a miss may be expected
    task automatic wstr(input int lim, input bit must);
        t = 0;
        do begin
            @(negedge clk);
            t++;
        end while (core_sample_strobe !== 1'b1 && t < lim);
        if (must && core_sample_strobe !== 1'b1) begin
            n_fail++;
            end_of_test;
        end
    endtask
    task automatic chk_first(input int dv);
        t = cyc - c0;
        chk(32'(t >= 25 * dv - 2 && t <= 26 * dv + 4), 32'h1);
    endtask
    // ----------
    // scenarios
    // ----------
    task automatic t_regs;
        rdc(4'h0, 8'h00);
        rdc(4'h4, 8'h00);
        rdc(4'hC, 8'h00);
        bus(1'b1, 4'h2, 8'h5A);
        rdc(4'h2, 8'h00);
        bus(1'b1, 4'h0, 8'hFF);
        @(negedge clk);
        chk(32'(core_path.reference), 32'h3);
        rdc(4'h0, 8'hFF);
        bus(1'b1, 4'h0, 8'h00);
    endtask
    task automatic t_single;
        bus(1'b1, 4'h4, 8'hC8);
        c0 = cyc;
        rdc(4'h4, 8'hC8);
        bus(1'b1, 4'h0, 8'h1E);
        @(negedge clk);
        chk(32'(core_path.bandgap), 32'h0);
        wstr(200, 1'b1);
        chk_first(2);
        wstr(80, 1'b0);
        chk(32'(core_sample_strobe), 32'h0);
        rdc(4'h4, 8'h98);
        chk(32'(done_irq), 32'h1);
        rdc(4'h8, 8'h35);
        rdc(4'hC, 8'h00);
        bus(1'b1, 4'h0, 8'h3E);
        rdc(4'h8, 8'h40);
        rdc(4'hC, 8'h0D);
        irq_vector_ack <= 1'b1;
        @(posedge clk);
        irq_vector_ack <= 1'b0;
        rdc(4'h4, 8'h88);
        chk(32'(done_irq), 32'h0);
    endtask
    task automatic t_lock;
        rdc(4'h8, 8'h40);
        bus(1'b1, 4'h4, 8'hC8);
        @(negedge clk);
        chk(32'(core_path.bandgap), 32'h1);
        wstr(120, 1'b0);
        rdc(4'hC, 8'h0D);
        bus(1'b1, 4'h4, 8'hC8);
        wstr(120, 1'b1);
        rdc(4'h8, 8'hC0);
        rdc(4'hC, 8'hF0);
        global_irq_enable <= 1'b0;
        rdc(4'h4, 8'h98);
        chk(32'(done_irq), 32'h0);
        bus(1'b1, 4'h4, 8'h88);
        rdc(4'h4, 8'h98);
        bus(1'b1, 4'h4, 8'h98);
        rdc(4'h4, 8'h88);
    endtask
    task automatic t_diff;
        for (int i = 0; i < 4; i++) begin
            bus(1'b1, 4'h0, {3'h0, DT[i][12:8]});
            bus(1'b1, 4'h4, 8'hC0);
            wstr(120, 1'b1);
            chk(32'({core_path.pos_input, core_path.neg_input,
                     core_path.gain_sel}), 32'(DT[i][7:0]));
            s = {DT[i][7:0], 2'h1} ^ 10'h200;
            rdc(4'h8, s[7:0]);
            rdc(4'hC, {6'h00, s[9:8]});
        end
    endtask
    task automatic t_div;
        for (int c = 0; c < 8; c++) begin
            d = (c == 0) ? 2 : 1 << c;
            bus(1'b1, 4'h4, 8'h10);
            bus(1'b1, 4'h4, 8'hE0 | 8'(c));
            c0 = cyc;
            wstr(5000, 1'b1);
            chk_first(d);
            wstr(5000, 1'b1);
            chk(t, 13 * d);
        end
        bus(1'b1, 4'h4, 8'h10);
        @(negedge clk);
        chk(32'(core_power_on), 32'h0);
    endtask
    task automatic t_abort;
        bus(1'b1, 4'h4, 8'hC0);
        repeat (10) @(posedge clk);
        bus(1'b1, 4'h4, 8'h00);
        wstr(80, 1'b0);
        chk(32'(core_sample_strobe), 32'h0);
        rdc(4'h4, 8'h00);
    endtask
    initial begin
        {rst_n, avs_read, avs_write, irq_vector_ack} = 4'h0;
        {n_fail, cmp_count, cyc} = '0;
        global_irq_enable = 1'b1;
        avs_address = 4'h0;
        avs_writedata = 32'h0;
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        t_regs;
        t_single;
        t_lock;
        t_diff;
        t_div;
        t_abort;
        end_of_test;
    end
endmodule // adc_control_and_result_regs_tb
`default_nettype wire
